// ==== hdl/srfpl_defs.vh ====
// Purpose: Shared constants for the segment rights and far pointer load unit.
// Assumes: APB register map with 32-bit data, one aligned word per register.
// Notes:   Included by the core and by the descriptor checker.
`ifndef SRFPL_DEFS_VH
`define SRFPL_DEFS_VH

// ==========================================================================
// Register offsets
`define SRFPL_OFF_CTRL      8'h00
`define SRFPL_OFF_OPCODE    8'h04
`define SRFPL_OFF_SELECTOR  8'h08
`define SRFPL_OFF_OFFSET    8'h0c
`define SRFPL_OFF_DESC      8'h10
`define SRFPL_OFF_LIMITS    8'h14
`define SRFPL_OFF_DEST      8'h18
`define SRFPL_OFF_FLAGS     8'h1c
`define SRFPL_OFF_GO        8'h20
`define SRFPL_OFF_STATUS    8'h24
`define SRFPL_SEG_BASE      3'h2
`define SRFPL_HID_BASE      3'h3
`define SRFPL_NUM_SEG       5

// ==========================================================================
// Control fields
`define SRFPL_CTRL_MODE_LO  0
`define SRFPL_CTRL_OPS32    2
`define SRFPL_CTRL_SRCMEM   3
`define SRFPL_CTRL_LVL_LO   4
`define SRFPL_CTRL_ACEN     6
`define SRFPL_CTRL_MISAL    7
`define SRFPL_CTRL_LIMERR   8
`define SRFPL_CTRL_MSEG_LO  9
`define SRFPL_CTRL_W        12
`define SRFPL_MODE_REAL     2'h0
`define SRFPL_MODE_PROT     2'h1
`define SRFPL_MODE_V86      2'h2
`define SRFPL_ZERO_BIT      0
`define SRFPL_CTRL_RST      12'h000
`define SRFPL_FLAGS_RST     32'h00000000

// ==========================================================================
// Operations and segment indices
`define SRFPL_OPC_RIGHTS    16'h0f02
`define SRFPL_OPC_DATA      16'h00c5
`define SRFPL_OPC_STACK     16'h0fb2
`define SRFPL_OPC_EXTRA     16'h00c4
`define SRFPL_OPC_FSEG      16'h0fb4
`define SRFPL_OPC_GSEG      16'h0fb5
`define SRFPL_OP_RIGHTS     3'h7
`define SRFPL_OP_BAD        3'h6
`define SRFPL_SEG_DATA      3'h0
`define SRFPL_SEG_STACK     3'h1
`define SRFPL_SEG_EXTRA     3'h2
`define SRFPL_SEG_F         3'h3
`define SRFPL_SEG_G         3'h4

// ==========================================================================
// Fault kinds
`define SRFPL_FLT_NONE      3'h0
`define SRFPL_FLT_UD        3'h1
`define SRFPL_FLT_GP        3'h2
`define SRFPL_FLT_SS        3'h3
`define SRFPL_FLT_NP        3'h4
`define SRFPL_FLT_AC        3'h5

// ==========================================================================
// Descriptor and selector fields, rights masks
`define SRFPL_D_TYPE_LO     8
`define SRFPL_D_S           12
`define SRFPL_D_LVL_LO      13
`define SRFPL_D_P           15
`define SRFPL_S_TI          2
`define SRFPL_MASK16        16'hff00
`define SRFPL_MASK32        32'h00f0ff00

`endif

// ==== hdl/srfpl_desc_check.v ====
// Purpose: Classifies a selector and descriptor for the rights and far loads.
// Assumes: Purely combinational; inputs held stable by the core.
// Notes:   Outputs are raw check results; fault priority lives in the core.
`include "srfpl_defs.vh"
`default_nettype none

module srfpl_desc_check (
  input  wire [15:0] sel,
  input  wire [31:0] desc_hi,
  input  wire [15:0] gbl_limit,
  input  wire [15:0] lcl_limit,
  input  wire [1:0]  cur_lvl,
  output wire        sel_null,
  output wire        in_limit,
  output wire        present,
  output wire        rights_ok,
  output wire        ss_bad,
  output wire        dseg_bad
);

  wire [3:0] dtype;
  wire       sys_n;
  wire [1:0] desc_lvl;
  wire [1:0] req_lvl;
  wire [15:0] limit;
  wire       is_code;
  wire       conforming;
  wire       type_ok;
  wire       priv_ok;

  assign dtype      = desc_hi[`SRFPL_D_TYPE_LO+3:`SRFPL_D_TYPE_LO];
  assign sys_n      = desc_hi[`SRFPL_D_S];
  assign desc_lvl   = desc_hi[`SRFPL_D_LVL_LO+1:`SRFPL_D_LVL_LO];
  assign req_lvl    = sel[1:0];
  assign present    = desc_hi[`SRFPL_D_P];
  assign is_code    = sys_n & dtype[3];
  assign conforming = is_code & dtype[2];

  // ==========================================================================
  // Selector checks
  // null selector test
  assign sel_null = (sel[15:2] == 14'h0000);
  assign limit    = sel[`SRFPL_S_TI] ? lcl_limit : gbl_limit;
  assign in_limit = ({sel[15:3], 3'h7} <= limit);

  // ==========================================================================
  // Rights load checks
  // accepted descriptor types
  assign type_ok = sys_n | (dtype == 4'h1) | (dtype == 4'h2) | (dtype == 4'h3) |
                   (dtype == 4'h4) | (dtype == 4'h5) | (dtype == 4'h9) |
                   (dtype == 4'hb) | (dtype == 4'hc);
  assign priv_ok   = conforming | ((cur_lvl <= desc_lvl) & (req_lvl <= desc_lvl));
  assign rights_ok = ~sel_null & in_limit & type_ok & priv_ok;

  // ==========================================================================
  // Segment load checks
  // stack limit, level and type
  assign ss_bad = ~in_limit | (req_lvl != cur_lvl) | ~sys_n | dtype[3] | ~dtype[1] |
                  (desc_lvl != cur_lvl);
  assign dseg_bad = ~in_limit | ~sys_n | (dtype[3] & ~dtype[1]) |
                    (~conforming & (req_lvl > desc_lvl) & (cur_lvl > desc_lvl));

endmodule // srfpl_desc_check

`default_nettype wire

// ==== hdl/srfpl_core.v ====
// Purpose: Executes the access-rights load and the five far pointer loads.
// Assumes: Operands and descriptor words are placed in registers over APB.
// Notes:   One operation at a time; a start while busy is ignored.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "srfpl_defs.vh"
`default_nettype none

module srfpl_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         op_done,
  output reg         fault_raise,
  output reg  [2:0]  fault_kind,
  output reg  [15:0] fault_err
);

  // ==========================================================================
  // States
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  // ==========================================================================
  // Storage
  reg [`SRFPL_CTRL_W-1:0] ctrl_ff;
  reg [15:0]              opcode_ff;
  reg [15:0]              selector_ff;
  reg [31:0]              offset_ff;
  reg [31:0]              desc_ff;
  reg [31:0]              limits_ff;
  reg [31:0]              dest_ff;
  reg [31:0]              flags_ff;
  reg [1:0]               state_ff;
  reg                     done_ff;
  reg [2:0]               st_kind_ff;
  reg [15:0]              st_err_ff;
  reg [15:0]              seg_sel_ff [0:`SRFPL_NUM_SEG-1];
  reg                     seg_vld_ff [0:`SRFPL_NUM_SEG-1];
  reg [31:0]              seg_hid_ff [0:`SRFPL_NUM_SEG-1];
  integer                 i;

  // ==========================================================================
  // Helpers
  // opcode to segment
  function [2:0] srfpl_decode;
    input [15:0] opc;
    begin
      case (opc)
        `SRFPL_OPC_RIGHTS: srfpl_decode = `SRFPL_OP_RIGHTS;
        `SRFPL_OPC_DATA:   srfpl_decode = `SRFPL_SEG_DATA;
        `SRFPL_OPC_STACK:  srfpl_decode = `SRFPL_SEG_STACK;
        `SRFPL_OPC_EXTRA:  srfpl_decode = `SRFPL_SEG_EXTRA;
        `SRFPL_OPC_FSEG:   srfpl_decode = `SRFPL_SEG_F;
        `SRFPL_OPC_GSEG:   srfpl_decode = `SRFPL_SEG_G;
        default:           srfpl_decode = `SRFPL_OP_BAD;
      endcase
    end
  endfunction

  // A 16-bit destination keeps the upper half of the general register.
  function [31:0] srfpl_merge;
    input        wide;
    input [31:0] old_val;
    input [31:0] new_val;
    begin
      srfpl_merge = wide ? new_val : {old_val[31:16], new_val[15:0]};
    end
  endfunction

  // ==========================================================================
  // Control decode
  wire [1:0] mode     = ctrl_ff[`SRFPL_CTRL_MODE_LO+1:`SRFPL_CTRL_MODE_LO];
  wire       ops32    = ctrl_ff[`SRFPL_CTRL_OPS32];
  wire       src_mem  = ctrl_ff[`SRFPL_CTRL_SRCMEM];
  wire [1:0] cur_lvl  = ctrl_ff[`SRFPL_CTRL_LVL_LO+1:`SRFPL_CTRL_LVL_LO];
  wire       ac_en    = ctrl_ff[`SRFPL_CTRL_ACEN];
  wire       misal    = ctrl_ff[`SRFPL_CTRL_MISAL];
  wire       lim_err  = ctrl_ff[`SRFPL_CTRL_LIMERR];
  wire [2:0] mem_seg  = ctrl_ff[`SRFPL_CTRL_MSEG_LO+2:`SRFPL_CTRL_MSEG_LO];
  wire       prot     = (mode == `SRFPL_MODE_PROT);
  wire [2:0] op       = srfpl_decode(opcode_ff);

  wire sel_null;
  wire in_limit;
  wire present;
  wire rights_ok;
  wire ss_bad;
  wire dseg_bad;

  srfpl_desc_check u_check (
    .sel       (selector_ff),
    .desc_hi   (desc_ff),
    .gbl_limit (limits_ff[15:0]),
    .lcl_limit (limits_ff[31:16]),
    .cur_lvl   (cur_lvl),
    .sel_null  (sel_null),
    .in_limit  (in_limit),
    .present   (present),
    .rights_ok (rights_ok),
    .ss_bad    (ss_bad),
    .dseg_bad  (dseg_bad)
  );

  // ==========================================================================
  // Memory operand faults
  wire mseg_ok   = (mem_seg < `SRFPL_NUM_SEG);
  wire mseg_null = prot & mseg_ok & (mem_seg != `SRFPL_SEG_STACK) & ~seg_vld_ff[mem_seg];
  reg  [2:0] mem_kind;
  always @* begin
    mem_kind = `SRFPL_FLT_NONE;
    if (mseg_null) begin
      mem_kind = `SRFPL_FLT_GP;
    end else if (lim_err && mem_seg == `SRFPL_SEG_STACK) begin
      mem_kind = `SRFPL_FLT_SS;
    end else if (lim_err) begin
      mem_kind = `SRFPL_FLT_GP;
    end else if (ac_en && misal && (cur_lvl == 2'h3 || mode == `SRFPL_MODE_V86)) begin
      mem_kind = `SRFPL_FLT_AC;
    end
  end

  // ==========================================================================
  // Execution result
  reg [2:0]  x_kind;
  reg [15:0] x_err;
  reg        x_dest;
  reg [31:0] x_dest_val;
  reg        x_zero;
  reg        x_zero_val;
  reg        x_seg;
  reg        x_vld;
  reg        x_hid;
  always @* begin
    x_kind     = `SRFPL_FLT_NONE;
    x_err      = 16'h0000;
    x_dest     = 1'b0;
    x_dest_val = dest_ff;
    x_zero     = 1'b0;
    x_zero_val = 1'b0;
    x_seg      = 1'b0;
    x_vld      = 1'b0;
    x_hid      = 1'b0;
    if (op == `SRFPL_OP_BAD) begin
      x_kind = `SRFPL_FLT_UD;
    end else if (op == `SRFPL_OP_RIGHTS) begin
      if (!prot) begin
        x_kind = `SRFPL_FLT_UD;
      end else if (src_mem && mem_kind != `SRFPL_FLT_NONE) begin
        x_kind = mem_kind;
      end else begin
        x_zero = 1'b1;
        if (rights_ok) begin
          x_zero_val = 1'b1;
          x_dest   = 1'b1;
          x_dest_val = ops32 ? (desc_ff & `SRFPL_MASK32) :
                       {dest_ff[31:16], desc_ff[15:0] & `SRFPL_MASK16};
        end
      end
    end else if (!src_mem) begin
      x_kind = `SRFPL_FLT_UD;
    end else if (mem_kind != `SRFPL_FLT_NONE) begin
      x_kind = mem_kind;
    end else if (!prot) begin
      x_seg  = 1'b1;
      x_vld  = 1'b1;
      x_dest = 1'b1;
    end else if (op == `SRFPL_SEG_STACK) begin
      if (sel_null) begin
        x_kind = `SRFPL_FLT_GP;
      end else if (ss_bad) begin
        x_kind = `SRFPL_FLT_GP;
        x_err  = selector_ff;
      end else if (!present) begin
        x_kind = `SRFPL_FLT_SS;
        x_err  = selector_ff;
      end else begin
        x_seg  = 1'b1;
        x_vld  = 1'b1;
        x_hid  = 1'b1;
        x_dest = 1'b1;
      end
    end else if (sel_null) begin
      x_seg  = 1'b1;
      x_vld  = 1'b0;
      x_dest = 1'b1;
    end else if (dseg_bad) begin
      x_kind = `SRFPL_FLT_GP;
      x_err  = selector_ff;
    end else if (!present) begin
      x_kind = `SRFPL_FLT_NP;
      x_err  = selector_ff;
    end else begin
      x_seg  = 1'b1;
      x_vld  = 1'b1;
      x_hid  = 1'b1;
      x_dest = 1'b1;
    end
    if (op != `SRFPL_OP_RIGHTS && x_dest) begin
      x_dest_val = srfpl_merge(ops32, dest_ff, offset_ff);
    end
  end

  // ==========================================================================
  // APB slave
  wire       acc      = psel & penable;
  wire       wr       = acc & pwrite;
  wire [2:0] arr_idx  = paddr[4:2];
  wire       arr_hit  = (arr_idx < `SRFPL_NUM_SEG) && (paddr[1:0] == 2'h0);
  wire       seg_hit  = arr_hit && (paddr[7:5] == `SRFPL_SEG_BASE);
  wire       hid_hit  = arr_hit && (paddr[7:5] == `SRFPL_HID_BASE);
  reg        reg_hit;
  always @* begin
    case (paddr)
      `SRFPL_OFF_CTRL, `SRFPL_OFF_OPCODE, `SRFPL_OFF_SELECTOR, `SRFPL_OFF_OFFSET,
      `SRFPL_OFF_DESC, `SRFPL_OFF_LIMITS, `SRFPL_OFF_DEST, `SRFPL_OFF_FLAGS,
      `SRFPL_OFF_GO, `SRFPL_OFF_STATUS: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  end
  // Zero wait states; the shadow copies are read-only, so writes there fail.
  assign pready  = 1'b1;
  assign pslverr = acc & ~(reg_hit | ((seg_hit | hid_hit) & ~pwrite));

  wire start   = wr && paddr == `SRFPL_OFF_GO && pwdata[0] && state_ff == ST_IDLE;
  wire busy    = (state_ff == ST_EXEC);
  wire cfg_wr  = wr & ~busy;
  wire finish  = busy;
  wire dn_clr  = wr && paddr == `SRFPL_OFF_STATUS && pwdata[0];

  always @* begin
    prdata = 32'h00000000;
    if (acc && !pwrite) begin
      case (paddr)
        `SRFPL_OFF_CTRL:     prdata = {20'h00000, ctrl_ff};
        `SRFPL_OFF_OPCODE:   prdata = {16'h0000, opcode_ff};
        `SRFPL_OFF_SELECTOR: prdata = {16'h0000, selector_ff};
        `SRFPL_OFF_OFFSET:   prdata = offset_ff;
        `SRFPL_OFF_DESC:     prdata = desc_ff;
        `SRFPL_OFF_LIMITS:   prdata = limits_ff;
        `SRFPL_OFF_DEST:     prdata = dest_ff;
        `SRFPL_OFF_FLAGS:    prdata = flags_ff;
        `SRFPL_OFF_STATUS:   prdata = {st_err_ff, 11'h000, st_kind_ff, busy, done_ff};
        default: begin
          if (seg_hit) begin
            prdata = {15'h0000, seg_vld_ff[arr_idx], seg_sel_ff[arr_idx]};
          end else if (hid_hit) begin
            prdata = seg_hid_ff[arr_idx];
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Sequencer and registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= ST_IDLE;
      ctrl_ff     <= `SRFPL_CTRL_RST;
      opcode_ff   <= 16'h0000;
      selector_ff <= 16'h0000;
      offset_ff   <= 32'h00000000;
      desc_ff     <= 32'h00000000;
      limits_ff   <= 32'h00000000;
      dest_ff     <= 32'h00000000;
      flags_ff    <= `SRFPL_FLAGS_RST;
      done_ff     <= 1'b0;
      st_kind_ff  <= `SRFPL_FLT_NONE;
      st_err_ff   <= 16'h0000;
      op_done     <= 1'b0;
      fault_raise <= 1'b0;
      fault_kind  <= `SRFPL_FLT_NONE;
      fault_err   <= 16'h0000;
      for (i = 0; i < `SRFPL_NUM_SEG; i = i + 1) begin
        seg_sel_ff[i] <= 16'h0000;
        seg_vld_ff[i] <= 1'b0;
        seg_hid_ff[i] <= 32'h00000000;
      end
    end else begin
      op_done     <= 1'b0;
      fault_raise <= 1'b0;
      // Operands are frozen while an operation runs so the checks see one set.
      if (cfg_wr) begin
        case (paddr)
          `SRFPL_OFF_CTRL:     ctrl_ff     <= pwdata[`SRFPL_CTRL_W-1:0];
          `SRFPL_OFF_OPCODE:   opcode_ff   <= pwdata[15:0];
          `SRFPL_OFF_SELECTOR: selector_ff <= pwdata[15:0];
          `SRFPL_OFF_OFFSET:   offset_ff   <= pwdata;
          `SRFPL_OFF_DESC:     desc_ff     <= pwdata;
          `SRFPL_OFF_LIMITS:   limits_ff   <= pwdata;
          `SRFPL_OFF_DEST:     dest_ff     <= pwdata;
          `SRFPL_OFF_FLAGS:    flags_ff    <= pwdata;
          default: begin
          end
        endcase
      end
      // Completion wins over a clear in the same cycle.
      if (finish) begin
        done_ff <= 1'b1;
      end else if (dn_clr) begin
        done_ff <= 1'b0;
      end
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_ff    <= ST_IDLE;
          op_done     <= 1'b1;
          st_kind_ff  <= x_kind;
          st_err_ff   <= x_err;
          fault_kind  <= x_kind;
          fault_err   <= x_err;
          fault_raise <= (x_kind != `SRFPL_FLT_NONE);
          if (x_kind == `SRFPL_FLT_NONE) begin
            if (x_dest) begin
              dest_ff <= x_dest_val;
            end
            if (x_zero) begin
              flags_ff[`SRFPL_ZERO_BIT] <= x_zero_val;
            end
            if (x_seg) begin
              seg_sel_ff[op] <= selector_ff;
              seg_vld_ff[op] <= x_vld;
            end
            if (x_hid) begin
              seg_hid_ff[op] <= desc_ff;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // srfpl_core

`default_nettype wire

// ==== tb/srfpl_core_sva.sv ====
// Purpose: Port-level checker for the rights and far pointer load core.
// Assumes: Zero-wait APB and one operation in flight at a time.
// Notes:   Attached to the core by the bind at the foot of this file.
`include "srfpl_defs.vh"
`default_nettype none
module srfpl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        op_done,
  input wire logic        fault_raise,
  input wire logic [2:0]  fault_kind,
  input wire logic [15:0] fault_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Helper terms
  // A start is not qualified by busy, so the bench must not start while busy.
  wire logic go = psel & penable & pwrite & (paddr == `SRFPL_OFF_GO) & pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Assertions
  a_done_after_go: assert property (go |-> ##2 op_done)
    else $error("operation did not complete two cycles after start");
  a_done_has_start: assert property (op_done |-> $past(go, 2))
    else $error("completion without a start");
  a_fault_needs_done: assert property (
    fault_raise |-> op_done && fault_kind != `SRFPL_FLT_NONE)
    else $error("fault pulse without completion or kind");
  a_done_flags_fault: assert property (
    op_done && fault_kind != `SRFPL_FLT_NONE |-> fault_raise)
    else $error("faulting completion without fault pulse");
  a_done_one_cycle: assert property (op_done |=> !op_done)
    else $error("completion pulse longer than one cycle");
  a_result_holds: assert property (
    !op_done |-> $stable(fault_kind) && $stable(fault_err))
    else $error("fault result changed without completion");
  a_code_zero_faults: assert property (
    op_done && fault_kind inside {`SRFPL_FLT_UD, `SRFPL_FLT_AC} |-> fault_err == 16'h0000)
    else $error("opcode or alignment fault with nonzero code");
  a_read_idle_zero: assert property (!(psel && penable && !pwrite) |-> prdata == 0)
    else $error("read data outside a read access");
  cover property (op_done && !fault_raise);
  cover property (fault_raise && fault_kind == `SRFPL_FLT_GP);
  cover property (psel && penable && pslverr);
endmodule // srfpl_chk
bind srfpl_core srfpl_chk u_srfpl_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .op_done, .fault_raise, .fault_kind, .fault_err);
`default_nettype wire

// ==== tb/srfpl_mem.sv ====
// Purpose: Descriptor table model; returns the second dword for a selector.
// Assumes: Global table only; index taken from selector bits 7:3.
// Notes:   Indices 16 to 31 hold system descriptors of every type nibble.
`default_nettype none
module srfpl_mem (
  input  wire logic [15:0] sel,
  output var  logic [31:0] desc
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Table contents
  always_comb begin
    case (sel[7:3])
      5'd1: desc = 32'h00cf9a12;
      5'd2: desc = 32'h00cf9200;
      5'd3: desc = 32'h00cf1200;
      5'd4: desc = 32'h00cf8200;
      5'd5: desc = 32'h00cf9e00;
      5'd6: desc = 32'h00cfd200;
      default: desc = sel[7] ? {16'h0000, 4'he, sel[6:3], 8'h00} : 32'h00000000;
    endcase
  end
endmodule // srfpl_mem
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the rights and far pointer load core.
// Assumes: Zero-wait APB slave; descriptors come from the table model.
// Notes:   One idle cycle between transfers keeps each driver edge single.
`include "srfpl_defs.vh"
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, g, x); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_done, fault_raise, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, mdesc;
  logic [2:0] fault_kind;
  logic [15:0] fault_err, msel;
  int errors, compares, cyc, tn;
  logic [15:0] opcs [5] = '{16'h00c5, 16'h0fb2, 16'h00c4, 16'h0fb4, 16'h0fb5};
  srfpl_core u_srfpl_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .op_done, .fault_raise, .fault_kind, .fault_err);
  srfpl_mem m_mem (.sel(msel), .desc(mdesc));
  // ==========================================================================
  // Clock, timeout and closing report
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop;
    end
  end
  // ==========================================================================
  // Bus and operation tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    `CHK(rdat, x)
  endtask
  task automatic op(input [11:0] c, input [15:0] o, input [15:0] s, input [2:0] k,
                    input [15:0] e);
    msel = s;
    apb(1, `SRFPL_OFF_CTRL, {20'h0, c});
    apb(1, `SRFPL_OFF_OPCODE, {16'h0, o});
    apb(1, `SRFPL_OFF_SELECTOR, {16'h0, s});
    apb(1, `SRFPL_OFF_DESC, mdesc);
    apb(1, `SRFPL_OFF_GO, 32'h1);
    for (int n = 0; n < 8 && op_done !== 1'b1; n++) @(posedge pclk);
    `CHK(op_done, 1'b1)
    `CHK(fault_kind, k)
    `CHK(fault_raise, k != 0)
    if (k != 0) `CHK(fault_err, e)
  endtask
  task automatic tend;
    $display("test %0d done", tn);
    tn++;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, msel} = '0;
    presetn = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(`SRFPL_OFF_CTRL, 32'h0);
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    apb(0, 8'h30, 0);
    `CHK(rerr, 1'b1)
    apb(1, `SRFPL_OFF_LIMITS, 32'h00ff00ff);
    apb(1, `SRFPL_OFF_DEST, 32'haaaa5555);
    apb(1, `SRFPL_OFF_FLAGS, 32'h00000ac4);
    op(12'ha01, 16'h0f02, 16'h0008, 0, 0);
    rd(`SRFPL_OFF_DEST, 32'haaaa9a00);
    rd(`SRFPL_OFF_FLAGS, 32'h00000ac5);
    op(12'ha05, 16'h0f02, 16'h0008, 0, 0);
    rd(`SRFPL_OFF_DEST, 32'h00c09a00);
    tend;
    apb(1, `SRFPL_OFF_FLAGS, 32'h1);
    op(12'ha01, 16'h0f02, 16'h0003, 0, 0);
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    rd(`SRFPL_OFF_DEST, 32'h00c09a00);
    apb(1, `SRFPL_OFF_FLAGS, 32'h1);
    op(12'ha01, 16'h0f02, 16'h0100, 0, 0);
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    for (int t = 0; t < 16; t++) begin
      op(12'ha01, 16'h0f02, 16'h0080 | (t << 3), 0, 0);
      rd(`SRFPL_OFF_FLAGS, (32'h1a3e >> t) & 32'h1);
    end
    op(12'ha01, 16'h0f02, 16'h0031, 0, 0);
    rd(`SRFPL_OFF_FLAGS, 32'h1);
    op(12'ha01, 16'h0f02, 16'h0033, 0, 0);
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    op(12'ha01, 16'h0f02, 16'h002b, 0, 0);
    rd(`SRFPL_OFF_FLAGS, 32'h1);
    op(12'ha31, 16'h0f02, 16'h0030, 0, 0);
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    op(12'ha00, 16'h0f02, 16'h0008, `SRFPL_FLT_UD, 0);
    op(12'ha02, 16'h0f02, 16'h0008, `SRFPL_FLT_UD, 0);
    tend;
    for (int i = 0; i < 5; i++) begin
      apb(1, `SRFPL_OFF_OFFSET, 32'h12345670 | i);
      op(12'ha0d, opcs[i], 16'h0010, 0, 0);
      rd(`SRFPL_OFF_DEST, 32'h12345670 | i);
      rd(8'h40 + 4 * i, 32'h00010010);
      rd(8'h60 + 4 * i, 32'h00cf9200);
    end
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    apb(1, `SRFPL_OFF_DEST, 32'hffff0000);
    op(12'ha09, 16'h00c4, 16'h0010, 0, 0);
    rd(`SRFPL_OFF_DEST, 32'hffff5674);
    op(12'ha09, 16'h00c5, 16'h0002, 0, 0);
    rd(8'h40, 32'h00000002);
    op(12'h009, 16'h0f02, 16'h0008, `SRFPL_FLT_GP, 0);
    op(12'ha09, 16'h0fb2, 16'h0000, `SRFPL_FLT_GP, 0);
    op(12'ha09, 16'h0fb2, 16'h0011, `SRFPL_FLT_GP, 16'h0011);
    op(12'ha09, 16'h0fb2, 16'h0018, `SRFPL_FLT_SS, 16'h0018);
    rd(`SRFPL_OFF_STATUS, 32'h0018000d);
    apb(1, `SRFPL_OFF_STATUS, 32'h1);
    rd(`SRFPL_OFF_STATUS, 32'h0018000c);
    op(12'ha09, 16'h00c5, 16'h0018, `SRFPL_FLT_NP, 16'h0018);
    op(12'ha09, 16'h00c5, 16'h0020, `SRFPL_FLT_GP, 16'h0020);
    op(12'ha01, 16'h00c5, 16'h0010, `SRFPL_FLT_UD, 0);
    op(12'h309, 16'h0f02, 16'h0008, `SRFPL_FLT_SS, 0);
    op(12'h509, 16'h0f02, 16'h0008, `SRFPL_FLT_GP, 0);
    op(12'haf9, 16'h0f02, 16'h0008, `SRFPL_FLT_AC, 0);
    rd(8'h44, 32'h00010010);
    tend;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(8'h44, 32'h0);
    rd(`SRFPL_OFF_STATUS, 32'h0);
    rd(`SRFPL_OFF_FLAGS, 32'h0);
    tend;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
